// ===== pusm_pkg.sv
package pusm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // channel layout
  localparam int NUM_SINGLE   = 20;
  localparam int NUM_PAIR     = 4;
  localparam int NUM_CH       = 24;
  localparam int BASE_SINGLE  = 7;
  localparam int BASE_PAIR    = 2;
  localparam int FIRST_INPUT  = 12;
  localparam int FAULT_OFFSET = 108;

  // sinking singles read low when closed
  localparam logic [19:0] NPN_MASK   = 20'h0_03ff;
  // fixed stop kinds per channel, singles 0..19 then pairs 20..23
  localparam logic [23:0] TOP_MASK   = 24'h00_7c1f;
  localparam logic [23:0] ESTOP_MASK = 24'h3b_81e0;
  localparam logic [23:0] ELOCK_MASK = 24'hc4_0200;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam int          ADDR_W       = 6;
  localparam logic [5:0]  REG_CTRL     = 6'h00;
  localparam logic [5:0]  REG_STATUS   = 6'h04;
  localparam logic [5:0]  REG_LIVE     = 6'h08;
  localparam logic [5:0]  REG_IRQ_STAT = 6'h0c;
  localparam logic [5:0]  REG_IRQ_MASK = 6'h10;
  localparam logic [5:0]  REG_LATCHED  = 6'h14;

  localparam int CTRL_OPRST_BIT = 0;
  localparam int ST_TOP_BIT     = 0;
  localparam int ST_ESTOP_BIT   = 1;
  localparam int ST_LOCK_BIT    = 2;
  localparam int ST_FAULT_BIT   = 3;
  localparam int ST_CODE_LSB    = 8;
  localparam int IRQ_W          = 4;
  localparam int IRQ_FAULT_BIT  = 0;
  localparam int IRQ_LSET_BIT   = 1;
  localparam int IRQ_LCLR_BIT   = 2;
  localparam int IRQ_PAIR_BIT   = 3;

  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;
  localparam logic [23:0] CLOSED_RST   = 24'hff_ffff;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    STOP_NONE  = 2'b00,
    STOP_TOP   = 2'b01,
    STOP_ESTOP = 2'b10,
    STOP_ELOCK = 2'b11
  } pusm_stop_kind_t;

  typedef enum logic [1:0] {
    LK_IDLE     = 2'b00,
    LK_LOCKED   = 2'b01,
    LK_SEEN_OFF = 2'b10
  } pusm_lock_state_t;

  typedef struct packed {
    logic topStop;
    logic eStop;
    logic lockRelayOpen;
    logic lockInd;
  } pusm_stop_cmd_t;

  function automatic pusm_stop_kind_t stopKindOf(input logic [4:0] ch);
    if (TOP_MASK[ch]) return STOP_TOP;
    if (ESTOP_MASK[ch]) return STOP_ESTOP;
    if (ELOCK_MASK[ch]) return STOP_ELOCK;
    return STOP_NONE;
  endfunction

  // lowest channel wins when several open together
  function automatic logic [4:0] firstSet(input logic [23:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (v[i]) idx = 5'(i);
    end
    return idx;
  endfunction

endpackage

// ===== pusm_code_rom.sv
`timescale 1ns/1ps
module pusm_code_rom (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [4:0] addr,
  output logic      [7:0] code
);

  logic [7:0] code_q;

  // one code per channel; read data registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= 8'h00;
    end else begin
      code_q <= 8'(addr) + 8'(pusm_pkg::FIRST_INPUT)
              + 8'(pusm_pkg::FAULT_OFFSET);
    end
  end

  assign code = code_q;

endmodule // pusm_code_rom

// ===== pusm_stop_monitor.sv
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - opened input commands its stop, shows code
// - stop kinds are fixed constants
// - singles 12-16, 22-26 give top-stop
// - 17-20,27-29,31 e-stop; 21,30 with lockout
// - pairs 32-33 e-stop; 34-35 with lockout
// - lockout stops open relay, raise indication
// - lockout blocks restart until off-then-mode
// - twenty singles and four checked pairs
// - singles 12-21 sinking, rest sourcing
// - fault code is input number plus 108
module pusm_stop_monitor (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [19:0]            singlePin,
  input  wire logic [3:0]             pairPinA,
  input  wire logic [3:0]             pairPinB,
  input  wire logic                   strokeSelOff,
  input  wire logic                   jogMode,
  input  wire logic                   otherRunMode,
  input  wire logic                   operatorReset,
  input  wire logic [5:0]             awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [5:0]             araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  output pusm_pkg::pusm_stop_cmd_t    stopCmd,
  output logic                        restartBlock,
  output logic                        faultShown,
  output logic [7:0]                  faultCode,
  output logic                        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // input conditioning
  logic [23:0] closedVec;
  logic [23:0] prevClosed_q;
  logic [23:0] openEvt;
  logic [3:0]  pairDisagree;

  assign closedVec[19:0]  = singlePin ^ pusm_pkg::NPN_MASK;
  assign closedVec[23:20] = pairPinA & pairPinB;
  assign pairDisagree     = pairPinA ^ pairPinB;
  assign openEvt          = prevClosed_q & ~closedVec;

  // starting high means an input open at power-up still stops the press
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prevClosed_q <= pusm_pkg::CLOSED_RST;
    end else begin
      prevClosed_q <= closedVec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus write side
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        awHave_q;
  logic        wHave_q;
  logic [5:0]  awAddr_q;
  logic [31:0] wData_q;
  logic        wStrb0_q;
  logic        wrFire;
  logic        softReset;
  logic        clrReq;

  assign wrFire    = awHave_q & wHave_q & ~bvalid_q;
  assign softReset = wrFire & wStrb0_q
                   & (awAddr_q == pusm_pkg::REG_CTRL)
                   & wData_q[pusm_pkg::CTRL_OPRST_BIT];
  assign clrReq    = operatorReset | softReset;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      awHave_q  <= 1'b0;
      wHave_q   <= 1'b0;
      awAddr_q  <= 6'h00;
      wData_q   <= 32'h0000_0000;
      wStrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= pusm_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready_q) begin
        awready_q <= 1'b0;
        awHave_q  <= 1'b1;
        awAddr_q  <= awaddr;
      end
      if (wvalid && wready_q) begin
        wready_q <= 1'b0;
        wHave_q  <= 1'b1;
        wData_q  <= wdata;
        wStrb0_q <= wstrb[0];
      end
      if (wrFire) begin
        bvalid_q <= 1'b1;
        awHave_q <= 1'b0;
        wHave_q  <= 1'b0;
        case (awAddr_q)
          pusm_pkg::REG_CTRL,
          pusm_pkg::REG_IRQ_STAT,
          pusm_pkg::REG_IRQ_MASK: bresp_q <= pusm_pkg::RESP_OKAY;
          default:                bresp_q <= pusm_pkg::RESP_SLVERR;
        endcase
      end
      if (bvalid_q && bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stop latching
  pusm_pkg::pusm_stop_cmd_t stopCmd_q;
  pusm_pkg::pusm_stop_cmd_t stopCmd_d;
  pusm_pkg::pusm_lock_state_t lockState_q;
  pusm_pkg::pusm_lock_state_t lockState_d;
  logic [23:0] topEvt;
  logic [23:0] estopEvt;
  logic [23:0] elockEvt;
  logic        lockClear;
  logic        runSelected;

  always_comb begin
    for (int i = 0; i < pusm_pkg::NUM_CH; i++) begin
      topEvt[i]   = openEvt[i]
                  & (pusm_pkg::stopKindOf(5'(i)) == pusm_pkg::STOP_TOP);
      estopEvt[i] = openEvt[i]
                  & (pusm_pkg::stopKindOf(5'(i)) == pusm_pkg::STOP_ESTOP);
      elockEvt[i] = openEvt[i]
                  & (pusm_pkg::stopKindOf(5'(i)) == pusm_pkg::STOP_ELOCK);
    end
  end

  assign runSelected = jogMode | otherRunMode;

  // lockout only clears after the selector passes through off
  always_comb begin
    lockState_d = lockState_q;
    lockClear   = 1'b0;
    case (lockState_q)
      pusm_pkg::LK_IDLE: begin
        if (|elockEvt) lockState_d = pusm_pkg::LK_LOCKED;
      end
      pusm_pkg::LK_LOCKED: begin
        if (strokeSelOff) lockState_d = pusm_pkg::LK_SEEN_OFF;
      end
      pusm_pkg::LK_SEEN_OFF: begin
        if (|elockEvt) begin
          lockState_d = pusm_pkg::LK_LOCKED;
        end else if (runSelected && !strokeSelOff) begin
          lockState_d = pusm_pkg::LK_IDLE;
          lockClear   = 1'b1;
        end
      end
      default: lockState_d = pusm_pkg::LK_LOCKED;
    endcase
  end

  // a new event wins over a reset in the same cycle
  always_comb begin
    stopCmd_d = stopCmd_q;
    if (clrReq) begin
      stopCmd_d.topStop = 1'b0;
      stopCmd_d.eStop   = 1'b0;
    end
    if (|topEvt) stopCmd_d.topStop = 1'b1;
    if (|(estopEvt | elockEvt)) stopCmd_d.eStop = 1'b1;
    stopCmd_d.lockInd       = lockState_d != pusm_pkg::LK_IDLE;
    stopCmd_d.lockRelayOpen = lockState_d != pusm_pkg::LK_IDLE;
  end

  logic restartBlock_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stopCmd_q      <= '0;
      lockState_q    <= pusm_pkg::LK_IDLE;
      restartBlock_q <= 1'b0;
    end else begin
      stopCmd_q      <= stopCmd_d;
      lockState_q    <= lockState_d;
      restartBlock_q <= stopCmd_d.lockInd | stopCmd_d.eStop
                      | stopCmd_d.topStop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first-out fault capture and code lookup
  logic       faultValid_q;
  logic       faultShown_q;
  logic [4:0] faultIdx_q;
  logic [7:0] romCode;
  logic [23:0] latched_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      faultValid_q <= 1'b0;
      faultIdx_q   <= 5'h00;
      faultShown_q <= 1'b0;
      latched_q    <= 24'h00_0000;
    end else begin
      faultShown_q <= faultValid_q & ~clrReq;
      if (|openEvt && (!faultValid_q || clrReq)) begin
        faultValid_q <= 1'b1;
        faultIdx_q   <= pusm_pkg::firstSet(openEvt);
      end else if (clrReq) begin
        faultValid_q <= 1'b0;
      end
      latched_q <= (clrReq ? 24'h00_0000 : latched_q) | openEvt;
    end
  end

  pusm_code_rom u_code_rom (
    .clk   (clk),
    .rst_n (rst_n),
    .addr  (faultIdx_q),
    .code  (romCode)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupts
  logic [3:0] irqStat_q;
  logic [3:0] irqMask_q;
  logic [3:0] irqSet;
  logic [3:0] irqW1c;
  logic       irq_q;

  assign irqSet[pusm_pkg::IRQ_FAULT_BIT] = |openEvt;
  assign irqSet[pusm_pkg::IRQ_LSET_BIT]  = |elockEvt;
  assign irqSet[pusm_pkg::IRQ_LCLR_BIT]  = lockClear;
  assign irqSet[pusm_pkg::IRQ_PAIR_BIT]  =
    |(pairDisagree & prevClosed_q[23:20]);
  assign irqW1c = (wrFire && wStrb0_q
                   && awAddr_q == pusm_pkg::REG_IRQ_STAT)
                ? wData_q[3:0] : 4'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_q <= 4'h0;
      irqMask_q <= pusm_pkg::IRQ_MASK_RST;
      irq_q     <= 1'b0;
    end else begin
      irqStat_q <= (irqStat_q & ~irqW1c) | irqSet;
      if (wrFire && wStrb0_q && awAddr_q == pusm_pkg::REG_IRQ_MASK) begin
        irqMask_q <= wData_q[3:0];
      end
      irq_q <= |(((irqStat_q & ~irqW1c) | irqSet) & irqMask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus read side
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] statusWord;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[pusm_pkg::ST_TOP_BIT]   = stopCmd_q.topStop;
    statusWord[pusm_pkg::ST_ESTOP_BIT] = stopCmd_q.eStop;
    statusWord[pusm_pkg::ST_LOCK_BIT]  = stopCmd_q.lockInd;
    statusWord[pusm_pkg::ST_FAULT_BIT] = faultShown_q;
    statusWord[pusm_pkg::ST_CODE_LSB +: 8] = romCode;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= pusm_pkg::RESP_OKAY;
    end else begin
      if (arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rresp_q   <= pusm_pkg::RESP_OKAY;
        case (araddr)
          pusm_pkg::REG_CTRL:     rdata_q <= 32'h0000_0000;
          pusm_pkg::REG_STATUS:   rdata_q <= statusWord;
          pusm_pkg::REG_LIVE:     rdata_q <= {8'h00, ~closedVec};
          pusm_pkg::REG_IRQ_STAT: rdata_q <= {28'h000_0000, irqStat_q};
          pusm_pkg::REG_IRQ_MASK: rdata_q <= {28'h000_0000, irqMask_q};
          pusm_pkg::REG_LATCHED:  rdata_q <= {8'h00, latched_q};
          default: begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= pusm_pkg::RESP_SLVERR;
          end
        endcase
      end
      if (rvalid_q && rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign awready      = awready_q;
  assign wready       = wready_q;
  assign bvalid       = bvalid_q;
  assign bresp        = bresp_q;
  assign arready      = arready_q;
  assign rvalid       = rvalid_q;
  assign rdata        = rdata_q;
  assign rresp        = rresp_q;
  assign stopCmd      = stopCmd_q;
  assign restartBlock = restartBlock_q;
  assign faultShown   = faultShown_q;
  assign faultCode    = romCode;
  assign irq          = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  any_stop_a: assert property (|openEvt |=> stopCmd_q.topStop
    || stopCmd_q.eStop) else $error("open input gave no stop");
  top_stop_a: assert property (|(openEvt & pusm_pkg::TOP_MASK)
    |=> stopCmd_q.topStop) else $error("top-stop not commanded");
  estop_kind_a: assert property (|(openEvt & ~pusm_pkg::TOP_MASK)
    |=> stopCmd_q.eStop) else $error("e-stop not commanded");
  pair_stop_a: assert property (|openEvt[23:20]
    |=> stopCmd_q.eStop && !$past(closedVec[20] & closedVec[21]
        & closedVec[22] & closedVec[23])) else $error("pair stop lost");
  lock_set_a: assert property (|(openEvt & pusm_pkg::ELOCK_MASK)
    |=> stopCmd_q.lockRelayOpen && stopCmd_q.lockInd)
    else $error("lockout not raised");
  lock_block_a: assert property (stopCmd_q.lockInd
    |-> restartBlock_q) else $error("restart allowed under lockout");
  lock_clear_a: assert property ($fell(stopCmd_q.lockInd)
    |-> $past(lockState_q) == pusm_pkg::LK_SEEN_OFF && $past(runSelected))
    else $error("lockout cleared without selector sequence");
  // an operator reset right behind the event may legally hide the code
  pair_mismatch_a: assert property (prevClosed_q[20]
    && pairDisagree[0] |=> stopCmd_q.eStop
    ##1 (faultShown_q || $past(clrReq)))
    else $error("pair mismatch not faulted");
  code_value_a: assert property ($rose(faultValid_q) && !clrReq
    ##1 !clrReq |=> faultCode == 8'(faultIdx_q) + 8'd120)
    else $error("wrong fault code");
  stop_hold_a: assert property (stopCmd_q.eStop && !clrReq
    |=> stopCmd_q.eStop) else $error("e-stop dropped without reset");

  top_evt_c: cover property (|topEvt ##1 stopCmd_q.topStop);
  lock_cycle_c: cover property (|elockEvt ##[1:100] lockClear);
  pair_c: cover property (prevClosed_q[22] && pairDisagree[2]);
  axi_wr_c: cover property (wrFire ##1 bvalid_q && bready);

endmodule // pusm_stop_monitor

// ===== pusm_aux_equip.sv
`timescale 1ns/1ps
module pusm_aux_equip (
  input  wire logic        clk,
  input  wire logic [19:0] singleOpen,
  input  wire logic [3:0]  openA,
  input  wire logic [3:0]  openB,
  output logic      [19:0] singlePin,
  output logic      [3:0]  pairPinA,
  output logic      [3:0]  pairPinB
);
  ////////////////////////////////////////////////////////////////////////////
  // normally closed contacts; a sinking contact pulls low while closed
  // registered so the contacts answer one cycle after the command
  always_ff @(posedge clk) begin
    singlePin[9:0]  <= singleOpen[9:0];
    singlePin[19:10] <= ~singleOpen[19:10];
  end

  // each member moves on its own, so one-sided opens give disagreement
  always_ff @(posedge clk) begin
    pairPinA <= ~openA;
    pairPinB <= ~openB;
  end
endmodule // pusm_aux_equip

// ===== pusm_stop_monitor_tb.sv
`timescale 1ns/1ps
module pusm_stop_monitor_tb;
  logic                     clk;
  logic                     rst_n;
  logic [19:0]              singleOpen;
  logic [3:0]               openA;
  logic [3:0]               openB;
  logic [19:0]              singlePin;
  logic [3:0]               pairPinA;
  logic [3:0]               pairPinB;
  logic                     strokeSelOff;
  logic                     jogMode;
  logic                     otherRunMode;
  logic                     operatorReset;
  logic [5:0]               awaddr;
  logic                     awvalid;
  logic                     awready;
  logic [31:0]              wdata;
  logic [3:0]               wstrb;
  logic                     wvalid;
  logic                     wready;
  logic [1:0]               bresp;
  logic                     bvalid;
  logic                     bready;
  logic [5:0]               araddr;
  logic                     arvalid;
  logic                     arready;
  logic [31:0]              rdata;
  logic [1:0]               rresp;
  logic                     rvalid;
  logic                     rready;
  pusm_pkg::pusm_stop_cmd_t stopCmd;
  logic                     restartBlock;
  logic                     faultShown;
  logic [7:0]               faultCode;
  logic                     irq;
  logic                     shownSeen;
  logic [33:0]              expQ[$];
  logic [3:0]               cmd;
  logic [3:0]               mask;
  logic [7:0]               code;
  logic [1:0]               mode;
  logic                     lk;
  int                       n;
  int                       num_errors;
  int                       checks_done;

  pusm_aux_equip i_aux (.clk, .singleOpen, .openA, .openB, .singlePin,
    .pairPinA, .pairPinB);

  pusm_stop_monitor i_dut (.clk, .rst_n, .singlePin, .pairPinA, .pairPinB,
    .strokeSelOff, .jogMode, .otherRunMode, .operatorReset, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .stopCmd, .restartBlock, .faultShown, .faultCode, .irq);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp(input logic [33:0] got);
    logic [33:0] e;
    e = 'x;
    if (expQ.size() > 0) e = expQ.pop_front();
    chk(got, e);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] r);
    @(posedge clk);
    expQ.push_back({32'h0, r});
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [5:0] a, input logic [33:0] e);
    @(posedge clk);
    expQ.push_back(e);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // expected {top, estop, relay open, lock indication} per channel
  function automatic logic [3:0] expCmd(input int ch);
    if (ch <= 4 || (ch >= 10 && ch <= 14)) return 4'b1000;
    if (ch == 9 || ch == 18 || ch >= 22) return 4'b0111;
    return 4'b0100;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // one note per response, oldest first; the driver is strictly serial
  always @(posedge clk) begin
    if (bvalid === 1'b1 && bready === 1'b1) cmp({32'h0, bresp});
    if (rvalid === 1'b1 && rready === 1'b1) cmp({rresp, rdata});
    if (faultShown === 1'b1 && shownSeen === 1'b0)
      cmp({22'h0, stopCmd, faultCode});
    shownSeen = faultShown;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    {singleOpen, openA, openB} = 28'h000_0000;
    {strokeSelOff, jogMode, otherRunMode, operatorReset} = 4'h0;
    {awaddr, araddr, wdata, wstrb} = 48'h0000_0000_0000;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    num_errors = 0;
    checks_done = 0;
    shownSeen = 1'b0;
    void'($urandom(55));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    chk({29'h0, restartBlock, stopCmd}, 34'h0);
    // idle code field shows channel 0, qualified off by the fault bit
    axi_rd(pusm_pkg::REG_STATUS, {18'h0,
           8'(pusm_pkg::FIRST_INPUT + pusm_pkg::FAULT_OFFSET), 8'h00});
    axi_rd(pusm_pkg::REG_LIVE, 34'h0);
    axi_rd(pusm_pkg::REG_IRQ_MASK, {30'h0, pusm_pkg::IRQ_MASK_RST});
    axi_rd(pusm_pkg::REG_CTRL, 34'h0);
    axi_rd(6'h18, {pusm_pkg::RESP_SLVERR, 32'h0});
    axi_wr(6'h18, 32'h1, 4'hf, pusm_pkg::RESP_SLVERR);
    axi_wr(pusm_pkg::REG_STATUS, 32'h1, 4'hf, pusm_pkg::RESP_SLVERR);
    axi_wr(pusm_pkg::REG_IRQ_MASK, 32'hf, 4'he, pusm_pkg::RESP_OKAY);
    axi_rd(pusm_pkg::REG_IRQ_MASK, 34'h0);
    $display("register test done");
    for (int ch = 0; ch < 24; ch++) begin
      cmd = expCmd(ch);
      lk = cmd[0];
      code = 8'(120 + ch);
      mask = ch[0] ? 4'h0 : 4'hf;
      mode = 2'($urandom_range(3, 1));
      axi_wr(pusm_pkg::REG_IRQ_MASK, {28'h0, mask}, 4'hf,
             pusm_pkg::RESP_OKAY);
      repeat ($urandom_range(3, 0)) @(posedge clk);
      expQ.push_back({22'h0, cmd, code});
      if (ch < 20) singleOpen[ch] <= 1'b1;
      else begin
        openA[ch - 20] <= mode[0];
        openB[ch - 20] <= mode[1];
      end
      for (n = 0; n < 8 && faultShown !== 1'b1; n++) @(posedge clk);
      chk({32'h0, faultShown, restartBlock}, 34'h3);
      singleOpen <= 20'h0_0000;
      openA <= 4'h0;
      openB <= 4'h0;
      repeat (3) @(posedge clk);
      chk({33'h0, irq}, {33'h0, ch[0] == 1'b0});
      axi_rd(pusm_pkg::REG_IRQ_STAT,
             {30'h0, ch >= 20 && mode != 2'd3, 1'b0, lk, 1'b1});
      // input is closed again here, so the stop must still be held
      axi_rd(pusm_pkg::REG_STATUS,
             {18'h0, code, 4'h0, 1'b1, lk, cmd[2], cmd[3]});
      axi_rd(pusm_pkg::REG_LATCHED,
             {10'h0, 24'h00_0001 << ch});
      if (ch[0]) axi_wr(pusm_pkg::REG_CTRL, 32'h1, 4'hf, pusm_pkg::RESP_OKAY);
      else begin
        @(posedge clk);
        operatorReset <= 1'b1;
        @(posedge clk);
        operatorReset <= 1'b0;
      end
      repeat (3) @(posedge clk);
      chk({29'h0, restartBlock, stopCmd}, {29'h0, lk, 2'b00, lk, lk});
      if (lk) begin
        strokeSelOff <= 1'b1;
        @(posedge clk);
        strokeSelOff <= 1'b0;
        jogMode <= ch[1];
        otherRunMode <= ~ch[1];
        @(posedge clk);
        jogMode <= 1'b0;
        otherRunMode <= 1'b0;
        repeat (3) @(posedge clk);
        chk({29'h0, restartBlock, stopCmd}, 34'h0);
      end
      axi_wr(pusm_pkg::REG_IRQ_STAT, 32'hf, 4'hf, pusm_pkg::RESP_OKAY);
      repeat (3) @(posedge clk);
      chk({33'h0, irq}, 34'h0);
      $display("channel %0d done", ch);
    end
    // every operator reset empties the record, the last one included
    axi_rd(pusm_pkg::REG_LATCHED, 34'h0);
    report_and_stop();
  end
endmodule // pusm_stop_monitor_tb
